// >>> peripheral_disable_bank.sv
// Peripheral disable bank: six byte-wide disable registers behind an AXI4-Lite slave.
// Assumes a single clock, a synchronous active-low reset and a well-behaved master.
//
// Behaviour
// - Bit 7 of the serial and waveform register set disables the second async serial port.
// - Bit 4 of the logic cell register set disables the fourth logic cell.
// - Bit 3 of the logic cell register set disables the third logic cell.
// - Bit 2 of the logic cell register set disables the second logic cell.
// - Unimplemented bits of every disable register always read as zero.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "pmd_consts.svh"

module peripheral_disable_bank
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output pdb_pkg::offs_s   offs_q
);

  pdb_pkg::bus_s  st_q;
  pdb_pkg::bus_s  st_d;
  pdb_pkg::regs_s regs;
  pdb_pkg::offs_s offs_d;
  logic           wr_en;
  logic           wr_hit;

  // Read decode shared by the read path; stored values are already masked.
  function automatic logic [8:0] read_word(input pdb_pkg::regs_s r, input logic [7:0] a);
    logic [8:0] res;
    res = {1'b1, 8'h00};
    case (a)
      `PDB_OFF_DIS0:        res = {1'b1, r.dis0};
      `PDB_OFF_DIS1:        res = {1'b1, r.dis1};
      `PDB_OFF_DIS2:        res = {1'b1, r.dis2};
      `PDB_OFF_DIS3:        res = {1'b1, r.dis3};
      `PDB_OFF_SERIAL_WAVE: res = {1'b1, r.serial_wave & `PDB_MASK_SERIAL_WAVE};
      `PDB_OFF_LOGIC_CELL:  res = {1'b1, r.logic_cell & `PDB_MASK_LOGIC_CELL};
      default:              res = {1'b0, 8'h00};
    endcase
    return res;
  endfunction

  // A write commits once both address and data are held, lane 0 is strobed and no response is pending.
  assign wr_en = st_q.aw_held && st_q.w_held && !st_q.bvalid && st_q.w_strb0;

  pdb_store u_store
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_en),
    .wr_addr (st_q.aw_addr),
    .wr_data (st_q.w_data),
    .regs_q  (regs),
    .wr_hit  (wr_hit)
  );

  always_comb
  begin
    logic [8:0] rd;
    rd = read_word(regs, s_axi_araddr & 8'hfc);
    st_d = st_q;
    st_d.awready = 1'b0;
    st_d.wready = 1'b0;
    st_d.arready = 1'b0;
    if (s_axi_awvalid && st_q.awready)
    begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr & 8'hfc;
    end
    if (s_axi_wvalid && st_q.wready)
    begin
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata[7:0];
      st_d.w_strb0 = s_axi_wstrb[0];
    end
    if (st_q.aw_held && st_q.w_held && !st_q.bvalid)
    begin
      st_d.bvalid = 1'b1;
      // A write with lane 0 off changes nothing and is answered OKAY if mapped.
      st_d.bresp = wr_hit ? `PDB_RESP_OKAY : `PDB_RESP_SLVERR;
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
    end
    if (st_q.bvalid && s_axi_bready)
    begin
      st_d.bvalid = 1'b0;
    end
    st_d.awready = !st_d.aw_held && !st_q.awready && !st_d.bvalid;
    st_d.wready = !st_d.w_held && !st_q.wready && !st_d.bvalid;
    if (s_axi_arvalid && st_q.arready)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata = {24'h000000, rd[7:0]};
      st_d.rresp = rd[8] ? `PDB_RESP_OKAY : `PDB_RESP_SLVERR;
    end
    else if (st_q.rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
    end
    st_d.arready = !st_d.rvalid && !st_q.arready && !st_q.rvalid;
  end

  always_comb
  begin
    offs_d.async_serial_b_off = regs.serial_wave[`PDB_BIT_ASYNC_B];
    offs_d.async_serial_a_off = regs.serial_wave[`PDB_BIT_ASYNC_A];
    offs_d.sync_serial_off    = regs.serial_wave[`PDB_BIT_SYNC];
    offs_d.waveform_gen_off   = regs.serial_wave[`PDB_BIT_WAVE];
    offs_d.logic_cell_d_off   = regs.logic_cell[`PDB_BIT_CELL_D];
    offs_d.logic_cell_c_off   = regs.logic_cell[`PDB_BIT_CELL_C];
    offs_d.logic_cell_b_off   = regs.logic_cell[`PDB_BIT_CELL_B];
    offs_d.logic_cell_a_off   = regs.logic_cell[`PDB_BIT_CELL_A];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= '0;
      offs_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      offs_q <= offs_d;
    end
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

endmodule // peripheral_disable_bank

// >>> pmd_consts.svh
// Offsets, bit positions, masks and reset values of the peripheral disable bank.
// Assumes inclusion by its bare name; definitions only.
`ifndef PMD_CONSTS_SVH
`define PMD_CONSTS_SVH

`define PDB_OFF_DIS0        8'h00
`define PDB_OFF_DIS1        8'h04
`define PDB_OFF_DIS2        8'h08
`define PDB_OFF_DIS3        8'h0c
`define PDB_OFF_SERIAL_WAVE 8'h10
`define PDB_OFF_LOGIC_CELL  8'h14

`define PDB_MASK_DIS0        8'hc7
`define PDB_MASK_DIS1        8'h87
`define PDB_MASK_DIS2        8'h67
`define PDB_MASK_DIS3        8'h3f
`define PDB_MASK_SERIAL_WAVE 8'hd1
`define PDB_MASK_LOGIC_CELL  8'h1e

`define PDB_RESET_VALUE 8'h00

`define PDB_BIT_ASYNC_B   7
`define PDB_BIT_ASYNC_A   6
`define PDB_BIT_SYNC      4
`define PDB_BIT_WAVE      0
`define PDB_BIT_CELL_D    4
`define PDB_BIT_CELL_C    3
`define PDB_BIT_CELL_B    2
`define PDB_BIT_CELL_A    1

`define PDB_RESP_OKAY   2'h0
`define PDB_RESP_SLVERR 2'h2

`endif

// >>> pdb_pkg.sv
// Types shared by the peripheral disable bank and its register store.
// Assumes nothing beyond a SystemVerilog compiler.
package pdb_pkg;

  typedef struct packed {
    logic [7:0] dis0;
    logic [7:0] dis1;
    logic [7:0] dis2;
    logic [7:0] dis3;
    logic [7:0] serial_wave;
    logic [7:0] logic_cell;
  } regs_s;

  typedef struct packed {
    logic async_serial_b_off;
    logic async_serial_a_off;
    logic sync_serial_off;
    logic waveform_gen_off;
    logic logic_cell_d_off;
    logic logic_cell_c_off;
    logic logic_cell_b_off;
    logic logic_cell_a_off;
  } offs_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_strb0;
  } bus_s;

endpackage

// >>> pdb_store.sv
// Register store of the disable bank: applies a write, masking out unimplemented bits.
// Assumes a write strobe of one cycle with a word offset from the bus slave.
`timescale 1ns/100ps
`include "pmd_consts.svh"

module pdb_store
(
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           wr_en,
  input  wire logic [7:0]     wr_addr,
  input  wire logic [7:0]     wr_data,
  output pdb_pkg::regs_s      regs_q,
  output logic                wr_hit
);

  pdb_pkg::regs_s regs_d;

  always_comb
  begin
    regs_d = regs_q;
    wr_hit = 1'b1;
    case (wr_addr)
      `PDB_OFF_DIS0:        regs_d.dis0 = wr_data & `PDB_MASK_DIS0;
      `PDB_OFF_DIS1:        regs_d.dis1 = wr_data & `PDB_MASK_DIS1;
      `PDB_OFF_DIS2:        regs_d.dis2 = wr_data & `PDB_MASK_DIS2;
      `PDB_OFF_DIS3:        regs_d.dis3 = wr_data & `PDB_MASK_DIS3;
      `PDB_OFF_SERIAL_WAVE: regs_d.serial_wave = wr_data & `PDB_MASK_SERIAL_WAVE;
      `PDB_OFF_LOGIC_CELL:  regs_d.logic_cell = wr_data & `PDB_MASK_LOGIC_CELL;
      default:              wr_hit = 1'b0;
    endcase
    if (!wr_en)
    begin
      regs_d = regs_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      regs_q <= {6{`PDB_RESET_VALUE}};
    end
    else
    begin
      regs_q <= regs_d;
    end
  end

endmodule // pdb_store

// >>> pdb_checker_sva.sv
// Checker of the peripheral disable bank: disable outputs against the data written.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/100ps
module pdb_checker
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input pdb_pkg::offs_s   offs_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] a_q, d_q;
  logic       s_q, b_q, u4, u5;
  // Address and data are kept apart because the slave may take them in either order.
  always_ff @(posedge aclk)
  begin
    b_q <= s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) {s_q, d_q} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
  end
  assign u4 = s_axi_bvalid && !b_q && s_q && a_q[7:2] == 6'h04;
  assign u5 = s_axi_bvalid && !b_q && s_q && a_q[7:2] == 6'h05;
  property p_ab; u4 |=> offs_q[7] == d_q[7]; endproperty
  a_ab: assert property (p_ab) else $error("async b off wrong");
  property p_cd; u5 |=> offs_q[3] == d_q[4]; endproperty
  a_cd: assert property (p_cd) else $error("cell d off wrong");
  property p_cc; u5 |=> offs_q[2] == d_q[3]; endproperty
  a_cc: assert property (p_cc) else $error("cell c off wrong");
  property p_cb; u5 |=> offs_q[1] == d_q[2]; endproperty
  a_cb: assert property (p_cb) else $error("cell b off wrong");
  property p_rd; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data high bits set");
  property p_rest; u4 |=> offs_q[6:4] == {d_q[6], d_q[4], d_q[0]}; endproperty
  a_rest: assert property (p_rest) else $error("serial off bits wrong");
  property p_ca; u5 |=> offs_q[0] == d_q[1]; endproperty
  a_ca: assert property (p_ca) else $error("cell a off wrong");
  c_w4: cover property (u4);
  c_w5: cover property (u5);
  c_rd: cover property (s_axi_rvalid);
endmodule // pdb_checker

// >>> tb_peripheral_disable_bank.sv
// Testbench of the peripheral disable bank: random AXI4-Lite traffic against a register model.
// Assumes the bank answers each request well within the watchdog span.
`timescale 1ns/100ps
module tb_peripheral_disable_bank;
  localparam logic [7:0] msk [6] = '{8'hc7, 8'h87, 8'h67, 8'h3f, 8'hd1, 8'h1e};
  logic           aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic           s_axi_rvalid, s_axi_rready;
  logic [7:0]     s_axi_awaddr, s_axi_araddr;
  logic [31:0]    s_axi_wdata, s_axi_rdata, d, rd_d;
  logic [3:0]     s_axi_wstrb, st;
  logic [1:0]     s_axi_bresp, s_axi_rresp, r;
  logic [7:0]     mem [6];
  pdb_pkg::offs_s offs_q;
  int             n_errors, total_checks, k, i;

  peripheral_disable_bank uut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .offs_q
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] stb);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= dat;
    s_axi_wstrb   <= stb;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      r = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rchk(input int j);
    s_axi_araddr  <= 8'(j * 4);
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      rd_d = s_axi_rdata;
      r    = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
    chk(rd_d, (j < 6) ? {24'h0, mem[j]} : 32'h0);
    chk({30'h0, r}, (j < 6) ? 32'h0 : 32'h2);
  endtask

  // The disable outputs are worked out from the model, never from the design.
  function automatic logic [7:0] ex_offs();
    return {mem[4][7], mem[4][6], mem[4][4], mem[4][0], mem[5][4:1]};
  endfunction

  task automatic sweep();
    for (int j = 0; j < 7; j++)
      rchk(j);
    chk({24'h0, offs_q}, {24'h0, ex_offs()});
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    #200000;
    n_errors++;
    conclude();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    n_errors = 0;
    total_checks = 0;
    mem = '{default: 8'h00};
    void'($urandom(32'he91d9c50));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    sweep();
    $display("reset values test done");
    // The first four writes set and clear every implemented bit of both serial and logic cell registers.
    for (k = 0; k < 48; k++)
    begin
      i  = (k < 4) ? 4 + k / 2 : $urandom % 7;
      d  = (k < 4) ? {32{k[0]}} : $urandom;
      st = (k < 4) ? 4'hf : 4'($urandom);
      wr(8'(i * 4), d, st);
      if (i < 6 && st[0]) mem[i] = d[7:0] & msk[i];
      chk({30'h0, r}, (i < 6) ? 32'h0 : 32'h2);
      chk({24'h0, offs_q}, {24'h0, ex_offs()});
      rchk(i);
    end
    sweep();
    $display("random write test done");
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    mem = '{default: 8'h00};
    @(posedge aclk);
    sweep();
    $display("second reset test done");
    conclude();
  end
endmodule // tb_peripheral_disable_bank

bind peripheral_disable_bank pdb_checker u_chk
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .offs_q
);
